// [ddrp_consts.svh]
// Constants for the DDR pin control block: widths, encodings and timing counts
`ifndef DDRP_CONSTS_SVH
`define DDRP_CONSTS_SVH

// ==========================================
// Widths
`define DDRP_DQ_W        32
`define DDRP_LANES       4
`define DDRP_ADDR_W      12
`define DDRP_BANK_W      2
`define DDRP_FIFO_DEPTH  4
`define DDRP_WORD_W      72

// ==========================================
// Address field positions
`define DDRP_AP_BIT      10
`define DDRP_COL_MSB     8

// ==========================================
// Command codes {cs_n, ras_n, cas_n, we_n}
`define DDRP_CMD_NOP     4'h7
`define DDRP_CMD_ACT     4'h3
`define DDRP_CMD_RD      4'h5
`define DDRP_CMD_WR      4'h4
`define DDRP_CMD_PRE     4'h2
`define DDRP_CMD_REF     4'h1
`define DDRP_CMD_MRS     4'h0

// ==========================================
// Timing: write burst length in beats, read latency in cycles
`define DDRP_BURST_BEATS 3'h4
`define DDRP_RD_LAT      2'h2

`endif

// [ddrp_pkg.sv]
// Types for the DDR pin control block
package ddrp_pkg;

  // ==========================================
  // Control state of the device
  typedef enum logic [2:0] {
    DDRP_IDLE    = 3'b000,
    DDRP_ACTIVE  = 3'b001,
    DDRP_PPD     = 3'b010,
    DDRP_APD     = 3'b011,
    DDRP_SREF    = 3'b100
  } ddrp_state_t;

  // Command pins sampled together
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank_sel;
    logic [11:0] addr;
  } ddrp_cmd_t;

  // One captured write beat with its lane masks
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  lane_masks;
    logic [1:0]  bank_sel;
    logic [8:0]  col;
    logic [24:0] spare;
  } ddrp_beat_t;

endpackage

// [ddrp_fifo.sv]
// Small FIFO with valid/ready on both sides
`timescale 1ns/1ns
module ddrp_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_resetn,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];    // Storage words
  logic [AW-1:0]    wr_ptr_reg;     // Write pointer
  logic [AW-1:0]    rd_ptr_reg;     // Read pointer
  logic [AW:0]      count_reg;      // Words held
  logic             push;           // Accepted write
  logic             pop;            // Accepted read

  // ==========================================
  // Handshake
  assign o_in_ready  = (count_reg != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage write
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers wrap at depth, which is a power of two
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ==========================================
  // Checks
  a_fifo_no_overflow: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    count_reg == (AW+1)'(DEPTH) |-> !o_in_ready)
    else $error("fifo ready while full");

endmodule

// [ddrp_cmd_decode.sv]
// Command decoder: select gating and command classification
`timescale 1ns/1ns
`include "ddrp_consts.svh"
module ddrp_cmd_decode (
  // Registered command pins
  input  wire ddrp_pkg::ddrp_cmd_t i_cmd,
  // Decoded command strobes
  output logic                     o_act,
  output logic                     o_rd,
  output logic                     o_wr,
  output logic                     o_pre,
  output logic                     o_ref,
  output logic                     o_mrs
);

  logic [3:0] code; // Select is part of the code

  // ==========================================
  // Decode; a high select yields no command at all
  always_comb begin
    code  = {i_cmd.cs_n, i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n}; // [RULE7] [RULE8]
    o_act = (code == `DDRP_CMD_ACT);
    o_rd  = (code == `DDRP_CMD_RD);
    o_wr  = (code == `DDRP_CMD_WR);
    o_pre = (code == `DDRP_CMD_PRE);
    o_ref = (code == `DDRP_CMD_REF);
    o_mrs = (code == `DDRP_CMD_MRS);
  end

endmodule

// [ddrp_pin_ctrl.sv]
// Device-side pin control for a four-bank DDR memory, 32-bit organisation
// Contract
// [RULE1] Sample command pins on true clock rise
// [RULE2] One data word per clock half
// [RULE3] Sleep-gate high enables clocks and buffers
// [RULE4] Sleep-gate low picks power-down by bank state
// [RULE5] Self-refresh exit recognised without clock edge
// [RULE6] Power-down disables all but clock, gate
// [RULE7] Select low enables decoder, high masks
// [RULE8] Strobes and select form command together
// [RULE9] Masked bytes are not stored
// [RULE10] Masks captured on both strobe edges
// [RULE11] Lower and upper masks cover two bytes
// [RULE12] Lane masks 0-3 cover bytes 0-3
// [RULE13] Address carries row, column, opcode
// [RULE14] Bank select picks one of four
// [RULE15] Strobe driven edge-aligned with read data
// [RULE16] Masks ignored outside write transfers
`timescale 1ns/1ns
`include "ddrp_consts.svh"
module ddrp_pin_ctrl (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // Clock phase: high in first half of the memory clock period
  input  wire logic        i_diff_timing_pair,
  // Sleep gate
  input  wire logic        i_sleep_gate,
  // Command pins
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [1:0]  i_bank_sel,
  input  wire logic [11:0] i_addr,
  // Write data, one word per clock half
  input  wire logic [31:0] i_dq,
  input  wire logic [3:0]  i_lane_masks,
  input  wire logic [3:0]  i_lane_strobes,
  // Read data pins
  output logic      [31:0] o_dq,
  output logic             o_dq_oe,
  output logic      [3:0]  o_lane_strobes,
  output logic             o_lane_strobes_oe,
  // Array side: stored write words and read returns
  output logic      [31:0] o_store_data,
  output logic      [3:0]  o_store_byte_en,
  output logic      [1:0]  o_store_bank,
  output logic      [8:0]  o_store_col,
  output logic             o_store_valid,
  input  wire logic        i_store_ready,
  input  wire logic [31:0] i_array_rd_data,
  // Status
  output logic      [2:0]  o_state,
  output logic      [11:0] o_mode_opcode,
  output logic      [3:0]  o_bank_open,
  output logic             o_bufs_enabled
);

  // ==========================================
  // Input synchronisers (pins come from outside the clock domain)
  logic [1:0]  ck_sync_reg;          // Clock phase sync
  logic [1:0]  gate_sync_reg;        // Sleep-gate sync
  logic [17:0] cmd_s1_reg;           // Command first stage
  logic [17:0] cmd_s2_reg;           // Command second stage
  logic [39:0] dat_s1_reg;           // Data and mask first stage
  logic [39:0] dat_s2_reg;           // Data and mask second stage
  logic [3:0]  dqs_s1_reg;           // Strobe first stage
  logic [3:0]  dqs_s2_reg;           // Strobe second stage
  logic        ck_prev_reg;          // Previous phase for edge find
  logic [3:0]  dqs_prev_reg;         // Previous strobe level

  // Two flops on each pin group before anything reads them
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ck_sync_reg   <= '0;
      gate_sync_reg <= '0;
      cmd_s1_reg    <= 18'h3FFFF;
      cmd_s2_reg    <= 18'h3FFFF;
      dat_s1_reg    <= '0;
      dat_s2_reg    <= '0;
      dqs_s1_reg    <= '0;
      dqs_s2_reg    <= '0;
    end else begin
      ck_sync_reg   <= {ck_sync_reg[0], i_diff_timing_pair};
      gate_sync_reg <= {gate_sync_reg[0], i_sleep_gate};
      cmd_s1_reg    <= {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank_sel, i_addr};
      cmd_s2_reg    <= cmd_s1_reg;
      dat_s1_reg    <= {i_lane_masks, 4'h0, i_dq};
      dat_s2_reg    <= dat_s1_reg;
      dqs_s1_reg    <= i_lane_strobes;
      dqs_s2_reg    <= dqs_s1_reg;
    end
  end

  // Edge history, read only after the second stage
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ck_prev_reg  <= 1'b0;
      dqs_prev_reg <= '0;
    end else begin
      ck_prev_reg  <= ck_sync_reg[1];
      dqs_prev_reg <= dqs_s2_reg;
    end
  end

  // ==========================================
  // Edge and state terms
  ddrp_pkg::ddrp_state_t state_reg;  // Control state
  ddrp_pkg::ddrp_state_t state_next; // Next control state
  ddrp_pkg::ddrp_cmd_t   cmd;        // Sampled command pins
  logic        ck_rise;              // True clock rising crossing
  logic        ck_edge;              // Either crossing
  logic        bufs_on;              // Input buffers live
  logic [3:0]  dqs_edge;             // Strobe toggled, per lane
  logic        dec_act;              // Decoded activate
  logic        dec_rd;               // Decoded read
  logic        dec_wr;               // Decoded write
  logic        dec_pre;              // Decoded precharge
  logic        dec_ref;              // Decoded refresh
  logic        dec_mrs;              // Decoded mode set
  logic [3:0]  bank_open_reg;        // Open row flag per bank
  logic [11:0] opcode_reg;           // Mode opcode
  logic [2:0]  wr_beats_reg;         // Write beats left
  logic [1:0]  wr_bank_reg;          // Write target bank
  logic [8:0]  wr_col_reg;           // Write column, advances per beat
  logic [2:0]  rd_beats_reg;         // Read beats left
  logic [1:0]  rd_lat_reg;           // Read latency count
  logic [3:0]  mask_capt;            // Masks in force this beat
  logic        fifo_ready;           // Fill side ready
  logic        fifo_out_valid;       // Drain side valid
  logic [71:0] fifo_out;             // Drain side word
  ddrp_pkg::ddrp_beat_t beat_in;     // Beat into the FIFO
  ddrp_pkg::ddrp_beat_t beat_out;    // Beat out of the FIFO

  // One-hot bank decode, used by open and close
  function automatic logic [3:0] bank_onehot(input logic [1:0] b);
    bank_onehot = 4'h1 << b;
  endfunction

  assign cmd      = ddrp_pkg::ddrp_cmd_t'(cmd_s2_reg);
  assign ck_rise  = ck_sync_reg[1] && !ck_prev_reg;            // [RULE1]
  assign ck_edge  = ck_sync_reg[1] != ck_prev_reg;             // [RULE2]
  assign bufs_on  = gate_sync_reg[1] &&
                    (state_reg == ddrp_pkg::DDRP_IDLE || state_reg == ddrp_pkg::DDRP_ACTIVE); // [RULE3] [RULE6]
  assign dqs_edge = dqs_s2_reg ^ dqs_prev_reg;                 // [RULE10]

  ddrp_cmd_decode u_dec (
    .i_cmd (cmd),
    .o_act (dec_act),
    .o_rd  (dec_rd),
    .o_wr  (dec_wr),
    .o_pre (dec_pre),
    .o_ref (dec_ref),
    .o_mrs (dec_mrs)
  );

  // ==========================================
  // Power state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ddrp_pkg::DDRP_IDLE, ddrp_pkg::DDRP_ACTIVE: begin
        if (ck_rise && !gate_sync_reg[1]) begin
          // Gate low with an open row picks active power-down, else refresh picks self refresh, else power-down
          if (bank_open_reg != 4'h0) begin
            state_next = ddrp_pkg::DDRP_APD; // [RULE4]
          end else if (dec_ref) begin
            state_next = ddrp_pkg::DDRP_SREF; // [RULE4]
          end else begin
            state_next = ddrp_pkg::DDRP_PPD; // [RULE4]
          end
        end else if (ck_rise) begin
          state_next = (bank_open_reg != 4'h0) ? ddrp_pkg::DDRP_ACTIVE : ddrp_pkg::DDRP_IDLE;
        end
      end
      ddrp_pkg::DDRP_PPD: begin
        if (ck_rise && gate_sync_reg[1]) begin
          state_next = ddrp_pkg::DDRP_IDLE; // [RULE5]
        end
      end
      ddrp_pkg::DDRP_APD: begin
        if (ck_rise && gate_sync_reg[1]) begin
          state_next = ddrp_pkg::DDRP_ACTIVE; // [RULE5]
        end
      end
      ddrp_pkg::DDRP_SREF: begin
        // Exit needs no memory clock crossing, only the synchronised gate
        if (gate_sync_reg[1]) begin
          state_next = ddrp_pkg::DDRP_IDLE; // [RULE5]
        end
      end
      default: state_next = ddrp_pkg::DDRP_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= ddrp_pkg::DDRP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Bank rows and mode opcode, taken only on rising crossings with buffers live
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      bank_open_reg <= '0;
      opcode_reg    <= '0;
    end else if (ck_rise && bufs_on) begin
      if (dec_act) begin
        bank_open_reg <= bank_open_reg | bank_onehot(cmd.bank_sel); // [RULE14] [RULE13]
      end else if (dec_pre) begin
        // Address bit ten high closes every bank
        bank_open_reg <= cmd.addr[`DDRP_AP_BIT] ? 4'h0 : (bank_open_reg & ~bank_onehot(cmd.bank_sel)); // [RULE14]
      end else if ((dec_rd || dec_wr) && cmd.addr[`DDRP_AP_BIT]) begin
        bank_open_reg <= bank_open_reg & ~bank_onehot(cmd.bank_sel); // [RULE13]
      end
      if (dec_mrs) begin
        opcode_reg <= cmd.addr; // [RULE13]
      end
    end
  end

  // ==========================================
  // Write burst: one beat per strobe edge, masks taken with the data
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_beats_reg <= '0;
      wr_bank_reg  <= '0;
      wr_col_reg   <= '0;
    end else if (ck_rise && bufs_on && dec_wr) begin
      wr_beats_reg <= `DDRP_BURST_BEATS;
      wr_bank_reg  <= cmd.bank_sel;
      wr_col_reg   <= cmd.addr[`DDRP_COL_MSB:0];
    end else if (wr_beats_reg != 3'h0 && dqs_edge[0] && fifo_ready) begin
      wr_beats_reg <= wr_beats_reg - 3'h1;
      wr_col_reg   <= wr_col_reg + 9'h001;
    end
  end

  // Masks count only during a write beat; lane n masks byte n
  always_comb begin
    mask_capt = (wr_beats_reg != 3'h0) ? dat_s2_reg[39:36] : 4'h0; // [RULE16] [RULE12] [RULE11]
  end

  assign beat_in = '{data: dat_s2_reg[31:0], lane_masks: mask_capt,
                     bank_sel: wr_bank_reg, col: wr_col_reg, spare: 25'h0};

  // Buffer between strobe capture and the array; a full buffer stalls beats
  ddrp_fifo #(
    .WIDTH (`DDRP_WORD_W),
    .DEPTH (`DDRP_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_resetn    (i_resetn),
    .i_in_valid  (wr_beats_reg != 3'h0 && dqs_edge[0]),
    .i_in_data   (beat_in),
    .o_in_ready  (fifo_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out),
    .i_out_ready (i_store_ready || !o_store_valid)
  );
  assign beat_out = ddrp_pkg::ddrp_beat_t'(fifo_out);

  // Array store port: masked bytes get no enable
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_store_valid   <= 1'b0;
      o_store_data    <= '0;
      o_store_byte_en <= '0;
      o_store_bank    <= '0;
      o_store_col     <= '0;
    end else if (i_store_ready || !o_store_valid) begin
      o_store_valid   <= fifo_out_valid;
      o_store_data    <= beat_out.data;
      o_store_byte_en <= ~beat_out.lane_masks; // [RULE9]
      o_store_bank    <= beat_out.bank_sel;
      o_store_col     <= beat_out.col;
    end
  end

  // ==========================================
  // Read burst: data and strobe change on each clock crossing together
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_lat_reg   <= '0;
      rd_beats_reg <= '0;
    end else if (ck_rise && bufs_on && dec_rd) begin
      rd_lat_reg   <= `DDRP_RD_LAT;
      rd_beats_reg <= '0;
    end else if (rd_lat_reg != 2'h0 && ck_rise) begin
      rd_lat_reg <= rd_lat_reg - 2'h1;
      if (rd_lat_reg == 2'h1) begin
        rd_beats_reg <= `DDRP_BURST_BEATS;
      end
    end else if (rd_beats_reg != 3'h0 && ck_edge) begin
      rd_beats_reg <= rd_beats_reg - 3'h1; // [RULE2]
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dq              <= '0;
      o_dq_oe           <= 1'b0;
      o_lane_strobes    <= '0;
      o_lane_strobes_oe <= 1'b0;
    end else begin
      o_dq_oe           <= (rd_beats_reg != 3'h0) && bufs_on; // [RULE3]
      o_lane_strobes_oe <= (rd_beats_reg != 3'h0) && bufs_on;
      if (rd_beats_reg != 3'h0 && ck_edge) begin
        o_dq           <= i_array_rd_data;
        // First beat rises out of the low preamble, last one falls back to it
        o_lane_strobes <= {4{~rd_beats_reg[0]}}; // [RULE15]
      end
    end
  end

  // Status outputs
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_state        <= '0;
      o_mode_opcode  <= '0;
      o_bank_open    <= '0;
      o_bufs_enabled <= 1'b0;
    end else begin
      o_state        <= state_reg;
      o_mode_opcode  <= opcode_reg;
      o_bank_open    <= bank_open_reg;
      o_bufs_enabled <= bufs_on; // [RULE6]
    end
  end

  // ==========================================
  // Checks
  a_deselect_no_act: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RULE7]
    cmd.cs_n |-> !(dec_act || dec_rd || dec_wr || dec_pre || dec_mrs))
    else $error("command decoded while deselected");
  a_act_opens_bank: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RULE14]
    ck_rise && bufs_on && dec_act |=> bank_open_reg[$past(cmd.bank_sel)])
    else $error("activate did not open bank");
  a_apd_when_open: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RULE4]
    (state_reg == ddrp_pkg::DDRP_IDLE || state_reg == ddrp_pkg::DDRP_ACTIVE) && ck_rise && !gate_sync_reg[1] &&
    bank_open_reg != 4'h0
    |=> state_reg == ddrp_pkg::DDRP_APD)
    else $error("open bank did not give active power-down");
  a_sleep_bufs_off: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RULE6]
    state_reg inside {ddrp_pkg::DDRP_PPD, ddrp_pkg::DDRP_APD, ddrp_pkg::DDRP_SREF} |=> !o_bufs_enabled)
    else $error("buffers live in power-down");
  a_mask_blocks_store: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RULE9]
    o_store_valid |-> o_store_byte_en == ~$past(beat_out.lane_masks) || !$past(i_store_ready || !o_store_valid))
    else $error("masked byte enabled");
  a_mask_only_write: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RULE16]
    wr_beats_reg == 3'h0 |-> mask_capt == 4'h0)
    else $error("mask used outside write");
  a_mrs_opcode: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RULE13]
    ck_rise && bufs_on && dec_mrs |=> opcode_reg == $past(cmd.addr))
    else $error("opcode not taken");
  a_read_drive: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RULE15]
    rd_beats_reg != 3'h0 && bufs_on |=> o_dq_oe && o_lane_strobes_oe)
    else $error("read data not driven");

endmodule

// [ddrp_ctrl_model.sv]
// Controller-side model: memory clock, command pins and write bursts
`timescale 1ns/1ns
`include "ddrp_consts.svh"
module ddrp_ctrl_model (
  // Clock
  input  wire logic        i_mclk,
  // Clock pair and sleep gate
  output logic             o_ck,
  output logic             o_gate,
  // Command pins
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic [1:0]       o_bank_sel,
  output logic [11:0]      o_addr,
  // Write data pins
  output logic [31:0]      o_dq = 32'h0,
  output logic [3:0]       o_masks = 4'h0,
  output logic [3:0]       o_strobes = 4'h0
);
  // ==========================================
  // State
  ddrp_pkg::ddrp_cmd_t cmd_reg = '1; // Pins travel as one unit
  logic                run = 1'b1;   // Clock stands still in self refresh
  logic                gate = 1'b1;  // Sleep gate level
  logic                idle = 1'b1;  // No write data owned on the wires
  logic [1:0]          ph = 2'h0;    // Memory clock phase count
  assign o_ck = ph[1];
  assign o_gate = gate;
  assign {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_bank_sel, o_addr} = cmd_reg;

  // Memory clock, four system cycles a period
  always @(posedge i_mclk) begin
    if (run) begin
      ph <= ph + 2'h1;
    end
  end

  // Released data lines never keep the last value
  always @(posedge i_mclk) begin
    if (idle) begin
      o_dq <= ~o_dq;
      o_masks <= ~o_masks;
    end
  end

  // Pins change on the falling half, held across the rising crossing
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    do @(posedge i_mclk); while (ph != 2'h3);
    cmd_reg <= {c, b, a};
    repeat (4) @(posedge i_mclk);
    cmd_reg <= {`DDRP_CMD_NOP, b, a};
  endtask

  // Self-refresh entry: refresh code and low gate meet the same rising crossing
  task automatic sref();
    do @(posedge i_mclk); while (ph != 2'h3);
    cmd_reg <= {`DDRP_CMD_REF, 2'h0, 12'h0};
    gate <= 1'b0;
    repeat (4) @(posedge i_mclk);
    cmd_reg <= {`DDRP_CMD_NOP, 2'h0, 12'h0};
  endtask

  // Four beats, strobe toggles centred on each data word
  task automatic burst(input logic [31:0] d [4], input logic [3:0] m [4]);
    idle <= 1'b0;
    repeat (3) @(posedge i_mclk);
    for (int i = 0; i < 4; i++) begin
      o_dq <= d[i];
      o_masks <= m[i];
      @(posedge i_mclk);
      o_strobes <= ~o_strobes;
      @(posedge i_mclk);
    end
    idle <= 1'b1;
  endtask
endmodule

// [ddrp_pin_ctrl_tb.sv]
// Self-checking bench for the DDR pin control block
`timescale 1ns/1ns
`include "ddrp_consts.svh"
module ddrp_pin_ctrl_tb;
  // ==========================================
  // Signals
  logic        i_mclk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_store_ready = 1'b0;
  logic [31:0] i_array_rd_data = 32'h0;
  logic        ck, gate, cs_n, ras_n, cas_n, we_n, dq_oe, s_oe, sv, bufs;
  logic [1:0]  bank, s_bank, b;
  logic [11:0] addr, opcode, op;
  logic [31:0] dq, o_dq, s_data;
  logic [3:0]  masks, stb, o_stb, be, b_open, last_stb;
  logic [8:0]  s_col;
  logic [2:0]  state;
  logic [7:0]  col;
  logic [31:0] d [4];
  logic [3:0]  m [4];
  logic [46:0] exp_q [$]; // Expected data, enables, bank, column
  logic        stall = 1'b1;
  int          n_fail = 0;
  int          check_count = 0;
  int          toggles = 0;
  int          t0;

  ddrp_ctrl_model i_ddrp_ctrl_model (.i_mclk, .o_ck(ck), .o_gate(gate), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_bank_sel(bank), .o_addr(addr), .o_dq(dq), .o_masks(masks), .o_strobes(stb));
  ddrp_pin_ctrl i_ddrp_pin_ctrl (.i_mclk, .i_resetn, .i_diff_timing_pair(ck), .i_sleep_gate(gate), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank_sel(bank), .i_addr(addr), .i_dq(dq),
    .i_lane_masks(masks), .i_lane_strobes(stb), .o_dq(o_dq), .o_dq_oe(dq_oe), .o_lane_strobes(o_stb),
    .o_lane_strobes_oe(s_oe), .o_store_data(s_data), .o_store_byte_en(be), .o_store_bank(s_bank),
    .o_store_col(s_col), .o_store_valid(sv), .i_store_ready, .i_array_rd_data, .o_state(state),
    .o_mode_opcode(opcode), .o_bank_open(b_open), .o_bufs_enabled(bufs));

  // ==========================================
  // Helpers
  initial forever #25 i_mclk = ~i_mclk;

  task automatic check(input logic [63:0] seen, input logic [63:0] expv);
    check_count++;
    if (seen !== expv) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  // Byte enables widened to a bit mask
  function automatic logic [31:0] bytes(input logic [3:0] e);
    logic [31:0] f;
    for (int i = 0; i < 4; i++) f[8*i +: 8] = {8{e[i]}};
    return f;
  endfunction

  task automatic settle();
    repeat (8) @(posedge i_mclk);
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Store port: random stalls, words compared in order
  always @(posedge i_mclk) begin
    i_store_ready <= stall ? 1'b0 : 1'($urandom_range(1, 0));
    if (sv === 1'b1 && i_store_ready === 1'b1) begin
      if (exp_q.size() == 0) check(64'h1, 64'h0);
      else check({s_data & bytes(be), be, s_bank, s_col}, exp_q.pop_front());
    end
  end

  // Read beats: each strobe change carries one word, drivers on
  always @(posedge i_mclk) begin
    if (s_oe === 1'b1 && o_stb !== last_stb) begin
      toggles <= toggles + 1;
      check({dq_oe, o_dq}, {1'b1, i_array_rd_data});
    end
    last_stb <= o_stb;
  end

  // Watchdog
  initial begin
    repeat (6000) @(posedge i_mclk);
    n_fail++;
    print_verdict();
  end

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(67));
    repeat (16) @(posedge i_mclk);
    i_resetn <= 1'b1;
    repeat (6) @(posedge i_mclk);
    op = 12'($urandom);
    i_ddrp_ctrl_model.cmd(`DDRP_CMD_MRS, 2'h0, op);
    settle();
    check(opcode, op);
    i_ddrp_ctrl_model.cmd(4'hB, 2'h1, 12'h0);
    settle();
    check(b_open, 4'h0);
    for (int k = 0; k < 3; k++) begin
      b = 2'($urandom);
      col = 8'($urandom);
      i_ddrp_ctrl_model.cmd(`DDRP_CMD_ACT, b, 12'($urandom));
      settle();
      check(b_open, 4'h1 << b);
      for (int i = 0; i < 4; i++) begin
        d[i] = $urandom;
        m[i] = (i == 0) ? 4'h0 : (i == 2) ? 4'hF : 4'($urandom);
        exp_q.push_back({d[i] & bytes(~m[i]), ~m[i], b, 9'(col) + 9'(i)});
      end
      stall <= 1'b1;
      i_ddrp_ctrl_model.cmd(`DDRP_CMD_WR, b, {4'h0, col});
      i_ddrp_ctrl_model.burst(d, m);
      settle();
      check(sv, 1'b1);
      stall <= 1'b0;
      for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge i_mclk);
      check(exp_q.size(), 0);
      i_array_rd_data <= $urandom;
      t0 = toggles;
      i_ddrp_ctrl_model.cmd(`DDRP_CMD_RD, b, 12'h400 | col);
      repeat (40) @(posedge i_mclk);
      check(toggles - t0, 4);
      check(b_open, 4'h0);
    end
    // Power-down with an open row, then precharge, then self refresh
    i_ddrp_ctrl_model.cmd(`DDRP_CMD_ACT, b, 12'h0);
    i_ddrp_ctrl_model.gate <= 1'b0;
    settle();
    check({state, bufs}, {3'h3, 1'b0});
    i_ddrp_ctrl_model.cmd(`DDRP_CMD_ACT, ~b, 12'h0);
    settle();
    check(b_open, 4'h1 << b);
    i_ddrp_ctrl_model.gate <= 1'b1;
    settle();
    check({state, bufs}, {3'h1, 1'b1});
    i_ddrp_ctrl_model.cmd(`DDRP_CMD_PRE, 2'h0, 12'h400);
    settle();
    check({state, b_open}, {3'h0, 4'h0});
    i_ddrp_ctrl_model.gate <= 1'b0;
    settle();
    check(state, 3'h2);
    i_ddrp_ctrl_model.gate <= 1'b1;
    settle();
    i_ddrp_ctrl_model.sref();
    settle();
    check(state, 3'h4);
    i_ddrp_ctrl_model.run <= 1'b0;
    settle();
    i_ddrp_ctrl_model.gate <= 1'b1;
    settle();
    check(state, 3'h0);
    i_ddrp_ctrl_model.run <= 1'b1;
    settle();
    print_verdict();
  end
endmodule
